// ==== src/wdg_regs.svh ====
// Register indices, field positions, reset values and codes of the watchdog block.
// Assumes byte address = 4 * index on a 32-bit register bus.
`ifndef WDG_REGS_SVH
`define WDG_REGS_SVH

`define WDG_IDX_W 12
`define WDG_IDX_CTRL 12'hFF0
`define WDG_IDX_UPPER 12'hFF1
`define WDG_IDX_HIGH 12'hFF2
`define WDG_IDX_LOW 12'hFF3

`define WDG_BIT_POR 7
`define WDG_BIT_STOP 6
`define WDG_BIT_TMO 5
`define WDG_BIT_EXT 4
`define WDG_BIT_SM 0

`define WDG_CODE_UNLOCK1 8'h55
`define WDG_CODE_UNLOCK2 8'hAA
`define WDG_CODE_SM_OFF 8'h81
`define WDG_CODE_SM_ON 8'h00

`define WDG_CNT_W 24
`define WDG_CNT_ZERO 24'h000000
`define WDG_CNT_ONE 24'h000001
`define WDG_CNT_MAX 24'hFFFFFF
`define WDG_RELOAD_RST 24'hFFFFFF

`define WDG_RESP_OKAY 2'h0
`define WDG_RESP_SLVERR 2'h2

`endif

// ==== src/wdg_pkg.sv ====
// Types shared by the watchdog time-out and reset-status block.
// Assumes wdg_regs.svh supplies all numeric constants.
package wdg_pkg;

   typedef enum logic [2:0] {LK_IDLE, LK_GOT_55, LK_OPEN, LK_WANT_HIGH, LK_WANT_LOW} wdg_lock_t;

   // Reset-cause flags, most significant first
   typedef struct packed {
      logic por;
      logic stop;
      logic tmo;
      logic external_reset_flag;
   } wdg_flags_t;

   // Reset and recovery causes reported by the chip reset logic
   typedef struct packed {
      logic ext_reset;
      logic debugger_reset;
      logic debug_pin_reset;
      logic pin_recovery;
   } wdg_cause_t;

endpackage : wdg_pkg

// ==== src/wdg_top.sv ====
// Watchdog counter, time-out response, unlock sequence and reset-status register.
// Assumes an AXI4-Lite master on clk_i and RC ticks already synchronous to clk_i.
//
// Operation
// - Time-out is declared when the down-counter reaches zero.
// - An option input picks interrupt or reset as time-out response.
// - Interrupt response outside stop: raise interrupt, set time-out flag.
// - After an interrupt time-out the counter wraps to all ones and continues.
// - Interrupt response in stop: stop recovery, interrupt, time-out and stop flags.
// - Reset response outside stop: force device reset, set time-out flag.
// - Reset response in stop: stop recovery instead, set time-out and stop flags.
// - Counter and oscillator keep running in stop mode by default.
// - 55h, AAh, then 81h or 00h disables or enables the watchdog in stop.
// - The stop disable setting matters only while in stop mode.
// - 55h, AAh, then upper, high, low reload bytes; reload writes only so.
// - Unlock writes leave every control/status bit unchanged.
// - Any other write with byte lane 0 enabled between steps relocks the sequence.
// - Reload copied into the counter on first enable and each refresh.
// - Reading control/status clears its upper four flags after returning them.
// - Power-on flag set by power-on, cleared by time-out or stop recovery.
// - Stop flag set by any stop recovery, cleared by power-on or non-stop time-out.
// - Time-out flag set by any time-out, cleared by power-on or pin recovery.
// - External flag set by reset pin, cleared by power-on or pin recovery.
// - Bit 0 reports the stop disable setting.
// - Debugger reset or debug-pin stop reset give power-on flag values.
// - Reload value is upper, high, low bytes, upper most significant.
// - Reload byte reads return the current counter bytes.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`include "wdg_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module wdg_top
   import wdg_pkg::*;
#(
   parameter int ADDR_W = 14
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic timeout_response_select_i,
   input wire logic always_on_i,
   input wire logic refresh_i,
   input wire logic debug_mode_i,
   input wire logic stop_mode_i,
   input wire logic rc_tick_i,
   input wire wdg_cause_t cause_i,
   output logic irq_o,
   output logic reset_req_o,
   output logic stop_recovery_o,
   output logic rc_osc_enable_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic aw_held_reg, w_held_reg, w_lane_reg, bvalid_reg, rvalid_reg;
   logic [`WDG_IDX_W-1:0] aw_idx_reg, ar_idx;
   logic [7:0] w_byte_reg, ctrl_rd;
   logic [1:0] bresp_reg, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic do_write, wr_ctrl, wr_upper, wr_high, wr_low, wr_hit, ar_hs, rd_ctrl;
   wdg_lock_t lock_reg, lock_next;
   logic [`WDG_CNT_W-1:0] reload_reg, count_reg;
   logic enabled_reg, sm_reg, running, load, timeout_evt;
   logic tmo_pulse_reg, tmo_in_stop_reg, tmo_resp_reg;
   wdg_flags_t flags_reg, flags_next;

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready = !w_held_reg && !bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign do_write = aw_held_reg && w_held_reg && w_lane_reg;
   assign wr_ctrl = do_write && (aw_idx_reg == `WDG_IDX_CTRL);
   assign wr_upper = do_write && (aw_idx_reg == `WDG_IDX_UPPER);
   assign wr_high = do_write && (aw_idx_reg == `WDG_IDX_HIGH);
   assign wr_low = do_write && (aw_idx_reg == `WDG_IDX_LOW);
   assign wr_hit = wr_ctrl || wr_upper || wr_high || wr_low;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_idx_reg <= '0;
         w_byte_reg <= 8'h00;
         w_lane_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `WDG_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            aw_idx_reg <= s_axi_awaddr[ADDR_W-1:2];
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            w_byte_reg <= s_axi_wdata[7:0];
            w_lane_reg <= s_axi_wstrb[0];
         end
         if (aw_held_reg && w_held_reg)
         begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_hit || !w_lane_reg) ? `WDG_RESP_OKAY : `WDG_RESP_SLVERR;
         end
         else if (s_axi_bready)
         begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign ar_hs = s_axi_arvalid && s_axi_arready;
   assign ar_idx = s_axi_araddr[ADDR_W-1:2];
   assign rd_ctrl = ar_hs && (ar_idx == `WDG_IDX_CTRL);
   assign ctrl_rd = {flags_reg, 3'b000, sm_reg};

   always_comb
   begin
      rdata_next = 32'h0000_0000;
      rresp_next = `WDG_RESP_OKAY;
      unique case (ar_idx)
         `WDG_IDX_CTRL: rdata_next[7:0] = ctrl_rd;
         `WDG_IDX_UPPER: rdata_next[7:0] = count_reg[23:16];
         `WDG_IDX_HIGH: rdata_next[7:0] = count_reg[15:8];
         `WDG_IDX_LOW: rdata_next[7:0] = count_reg[7:0];
         default: rresp_next = `WDG_RESP_SLVERR;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `WDG_RESP_OKAY;
      end
      else if (ar_hs)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
      else if (s_axi_rready)
      begin
         rvalid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Unlock sequence
   always_comb
   begin
      lock_next = lock_reg;
      if (do_write)
      begin
         lock_next = LK_IDLE;
         unique case (lock_reg)
            LK_IDLE: if (wr_ctrl && w_byte_reg == `WDG_CODE_UNLOCK1) lock_next = LK_GOT_55;
            LK_GOT_55: if (wr_ctrl && w_byte_reg == `WDG_CODE_UNLOCK2) lock_next = LK_OPEN;
            LK_OPEN: if (wr_upper) lock_next = LK_WANT_HIGH;
            LK_WANT_HIGH: if (wr_high) lock_next = LK_WANT_LOW;
            LK_WANT_LOW: lock_next = LK_IDLE;
         endcase
         if (wr_ctrl && w_byte_reg == `WDG_CODE_UNLOCK1 && lock_reg != LK_IDLE)
            lock_next = LK_GOT_55;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         lock_reg <= LK_IDLE;
      else
         lock_reg <= lock_next;
   end

   // Reload bytes, upper most significant
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         reload_reg <= `WDG_RELOAD_RST;
      else if (wr_upper && lock_reg == LK_OPEN)
         reload_reg[23:16] <= w_byte_reg;
      else if (wr_high && lock_reg == LK_WANT_HIGH)
         reload_reg[15:8] <= w_byte_reg;
      else if (wr_low && lock_reg == LK_WANT_LOW)
         reload_reg[7:0] <= w_byte_reg;
   end

   // Stop disable setting; unlock codes never touch it
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         sm_reg <= 1'b0;
      else if (wr_ctrl && lock_reg == LK_OPEN && w_byte_reg == `WDG_CODE_SM_OFF)
         sm_reg <= 1'b1;
      else if (wr_ctrl && lock_reg == LK_OPEN && w_byte_reg == `WDG_CODE_SM_ON)
         sm_reg <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Down-counter
   assign running = enabled_reg && !(stop_mode_i && sm_reg);
   assign rc_osc_enable_o = running;
   assign load = (!enabled_reg && (refresh_i || always_on_i))
      || (enabled_reg && (refresh_i || debug_mode_i));
   assign timeout_evt = running && rc_tick_i && !load && count_reg == `WDG_CNT_ONE;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         enabled_reg <= 1'b0;
      else if (refresh_i || always_on_i)
         enabled_reg <= 1'b1;
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         count_reg <= `WDG_CNT_MAX;
      else if (load)
         count_reg <= reload_reg;
      else if (running && rc_tick_i)
         count_reg <= count_reg - `WDG_CNT_ONE;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Time-out response
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tmo_pulse_reg <= 1'b0;
         tmo_in_stop_reg <= 1'b0;
         tmo_resp_reg <= 1'b0;
      end
      else
      begin
         tmo_pulse_reg <= timeout_evt;
         tmo_in_stop_reg <= stop_mode_i;
         tmo_resp_reg <= timeout_response_select_i;
      end
   end

   assign irq_o = tmo_pulse_reg && !tmo_resp_reg;
   assign reset_req_o = tmo_pulse_reg && tmo_resp_reg && !tmo_in_stop_reg;
   assign stop_recovery_o = tmo_pulse_reg && tmo_in_stop_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset-cause flags; events win over a read clear
   always_comb
   begin
      flags_next = flags_reg;
      if (rd_ctrl)
         flags_next = '0;
      if (cause_i.ext_reset)
         flags_next = '{por: 1'b0, stop: 1'b0, tmo: 1'b0, external_reset_flag: 1'b1};
      if (cause_i.pin_recovery)
         flags_next = '{por: 1'b0, stop: 1'b1, tmo: 1'b0, external_reset_flag: 1'b0};
      if (tmo_pulse_reg && tmo_in_stop_reg)
      begin
         flags_next.por = 1'b0;
         flags_next.stop = 1'b1;
         flags_next.tmo = 1'b1;
      end
      if (tmo_pulse_reg && !tmo_in_stop_reg)
      begin
         flags_next.por = 1'b0;
         flags_next.stop = 1'b0;
         flags_next.tmo = 1'b1;
         if (tmo_resp_reg)
            flags_next.external_reset_flag = 1'b0;
      end
      if (cause_i.debugger_reset || cause_i.debug_pin_reset)
         flags_next = '{por: 1'b1, stop: 1'b0, tmo: 1'b0, external_reset_flag: 1'b0};
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         flags_reg <= '{por: 1'b1, stop: 1'b0, tmo: 1'b0, external_reset_flag: 1'b0};
      else
         flags_reg <= flags_next;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_TMO_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      timeout_evt |=> count_reg == `WDG_CNT_ZERO ##0 tmo_pulse_reg)
      else $error("time-out not at zero count");

   AST_WRAP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (running && rc_tick_i && !load && count_reg == `WDG_CNT_ZERO)
      |=> count_reg == `WDG_CNT_MAX)
      else $error("counter did not wrap to maximum");

   AST_IRQ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (tmo_pulse_reg && !tmo_resp_reg && !tmo_in_stop_reg)
      |-> irq_o && !reset_req_o ##1 flags_reg.tmo)
      else $error("interrupt time-out response wrong");

   AST_RESET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (tmo_pulse_reg && tmo_resp_reg && !tmo_in_stop_reg)
      |-> reset_req_o && !irq_o && !stop_recovery_o ##1 flags_reg.tmo)
      else $error("reset time-out response wrong");

   AST_STOP_TMO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (tmo_pulse_reg && tmo_in_stop_reg && !cause_i.debugger_reset && !cause_i.debug_pin_reset)
      |-> stop_recovery_o && !reset_req_o ##1 (flags_reg.stop && flags_reg.tmo))
      else $error("stop-mode time-out response wrong");

   AST_RD_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_ctrl && !tmo_pulse_reg && cause_i == '0) |=> flags_reg == '0 && rvalid_reg)
      else $error("read did not clear flags");

   AST_RELOAD_LOCK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !$stable(reload_reg) |-> $past(lock_reg) inside {LK_OPEN, LK_WANT_HIGH, LK_WANT_LOW})
      else $error("reload changed while locked");
   AST_SM_LOCK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !$stable(sm_reg) |-> $past(lock_reg) == LK_OPEN && $past(wr_ctrl))
      else $error("stop setting changed outside sequence");
   AST_STOP_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (stop_mode_i && sm_reg && !load) |=> $stable(count_reg))
      else $error("counter moved while disabled in stop");

   AST_DBG_POR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (cause_i.debugger_reset || cause_i.debug_pin_reset) |=> flags_reg == 4'b1000)
      else $error("debug reset flags wrong");

endmodule : wdg_top

`default_nettype wire

// ==== dv/wdg_far_model.sv ====
// Far-side model: oscillator tick source and counter of response pulses.
// Assumes all inputs are synchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none

module wdg_far_model
#(
   parameter int TICK_DIV = 4
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic run_i,
   input wire logic osc_en_i,
   input wire logic irq_i,
   input wire logic reset_req_i,
   input wire logic stop_recovery_i,
   output logic rc_tick_o,
   output var integer n_irq_o,
   output var integer n_rst_o,
   output var integer n_rec_o
);
   int div_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Oscillator stands still while disabled
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         div_reg <= 0;
         rc_tick_o <= 1'b0;
      end
      else
      begin
         rc_tick_o <= 1'b0;
         if (run_i && osc_en_i)
         begin
            div_reg <= (div_reg == TICK_DIV - 1) ? 0 : div_reg + 1;
            rc_tick_o <= (div_reg == TICK_DIV - 1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt controller and reset logic see one event per pulse
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         n_irq_o <= 0;
         n_rst_o <= 0;
         n_rec_o <= 0;
      end
      else
      begin
         n_irq_o <= n_irq_o + irq_i;
         n_rst_o <= n_rst_o + reset_req_i;
         n_rec_o <= n_rec_o + stop_recovery_i;
      end
   end
endmodule : wdg_far_model

`default_nettype wire

// ==== dv/watchdog_timeout_and_reset_status_tb.sv ====
// Self-checking bench of the watchdog time-out and reset-status block.
// Assumes wdg_top with an AXI4-Lite slave and the far-side model.
`include "wdg_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module watchdog_timeout_and_reset_status_tb
   import wdg_pkg::*;
;
   localparam logic [13:0] A_CTRL = {`WDG_IDX_CTRL, 2'b00};
   localparam logic [13:0] A_UP = {`WDG_IDX_UPPER, 2'b00};
   localparam logic [13:0] A_HI = {`WDG_IDX_HIGH, 2'b00};
   localparam logic [13:0] A_LO = {`WDG_IDX_LOW, 2'b00};
   localparam logic [13:0] A_BAD = 14'h3FD0;
   localparam logic [1:0] OK = `WDG_RESP_OKAY;
   localparam logic [1:0] ERR = `WDG_RESP_SLVERR;
   logic clk_i = 1'b0, rst_n_i = 1'b0;
   logic [13:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic sel = 1'b0, stop = 1'b0, refr = 1'b0, run = 1'b0, dbg = 1'b0;
   wdg_cause_t cause = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic irq, rst_req, rec, osc_en, tick;
   integer n_irq, n_rst, n_rec;
   int errors = 0;
   int num_checks = 0;

   always #20 clk_i = ~clk_i;

   wdg_top #(.ADDR_W(14)) dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .timeout_response_select_i(sel), .always_on_i(1'b0), .refresh_i(refr),
      .debug_mode_i(dbg), .stop_mode_i(stop), .rc_tick_i(tick), .cause_i(cause),
      .irq_o(irq), .reset_req_o(rst_req), .stop_recovery_o(rec), .rc_osc_enable_o(osc_en));

   wdg_far_model #(.TICK_DIV(4)) far (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run), .osc_en_i(osc_en), .irq_i(irq),
      .reset_req_i(rst_req), .stop_recovery_i(rec), .rc_tick_o(tick), .n_irq_o(n_irq),
      .n_rst_o(n_rst), .n_rec_o(n_rec));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("Checks %0d, errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict

   task automatic hang();
      errors++;
      $display("Error at %0t: wait limit reached", $time);
      give_verdict();
   endtask : hang

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chkn(input integer got, input integer exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: event count %0d, expected %0d", $time, got, exp);
      end
   endtask : chkn

   ////////////////////////////////////////////////////////////////////////////////
   // Bus cycles
   task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_i);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         n++;
      end
      while (s_axi_bvalid !== 1'b1 && n < 50);
      s_axi_bready <= 1'b0;
      if (n >= 50)
         hang();
      chk8({6'h00, s_axi_bresp}, {6'h00, er});
   endtask : wr

   task automatic rd(input logic [13:0] a, input logic [7:0] exp, input logic [1:0] er);
      int n;
      @(posedge clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_i);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         n++;
      end
      while (s_axi_rvalid !== 1'b1 && n < 50);
      s_axi_rready <= 1'b0;
      if (n >= 50)
         hang();
      chk8(s_axi_rdata[7:0], exp);
      chk8({6'h00, s_axi_rresp}, {6'h00, er});
   endtask : rd

   task automatic unlock();
      wr(A_CTRL, `WDG_CODE_UNLOCK1, OK);
      wr(A_CTRL, `WDG_CODE_UNLOCK2, OK);
   endtask : unlock

   task automatic refresh();
      @(posedge clk_i);
      refr <= 1'b1;
      @(posedge clk_i);
      refr <= 1'b0;
   endtask : refresh

   // Cause bits: ext_reset, debugger_reset, debug_pin_reset, pin_recovery
   task automatic cause_pulse(input wdg_cause_t c);
      @(posedge clk_i);
      cause <= c;
      @(posedge clk_i);
      cause <= 4'h0;
   endtask : cause_pulse

   // Lets the oscillator run until one response pulse is seen
   task automatic wait_evt();
      int s;
      int n;
      s = n_irq + n_rst + n_rec;
      run <= 1'b1;
      for (n = 0; n < 400 && n_irq + n_rst + n_rec == s; n++)
         @(posedge clk_i);
      run <= 1'b0;
      if (n >= 400)
         hang();
   endtask : wait_evt

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      rd(A_CTRL, 8'h80, OK);
      rd(A_UP, 8'hFF, OK);
      rd(A_BAD, 8'h00, ERR);
      wr(A_BAD, 8'h12, ERR);
   endtask : t_reset

   task automatic t_reload();
      cause_pulse(4'h8);
      unlock();
      rd(A_CTRL, 8'h10, OK);
      wr(A_UP, 8'h00, OK);
      wr(A_HI, 8'h00, OK);
      wr(A_LO, 8'h08, OK);
      refresh();
      rd(A_LO, 8'h08, OK);
      rd(A_HI, 8'h00, OK);
   endtask : t_reload

   task automatic t_int();
      cause_pulse(4'h2);
      wait_evt();
      chkn(n_irq, 1);
      chkn(n_rst + n_rec, 0);
      rd(A_CTRL, 8'h20, OK);
      // One or two more ticks take the counter from zero past the wrap
      run <= 1'b1;
      repeat (6) @(posedge clk_i);
      run <= 1'b0;
      rd(A_UP, 8'hFF, OK);
      rd(A_CTRL, 8'h00, OK);
   endtask : t_int

   task automatic t_int_stop();
      stop <= 1'b1;
      refresh();
      wait_evt();
      stop <= 1'b0;
      chkn(n_rec, 1);
      chkn(n_irq, 2);
      rd(A_CTRL, 8'h60, OK);
   endtask : t_int_stop

   task automatic t_rst();
      sel <= 1'b1;
      cause_pulse(4'h1);
      refresh();
      wait_evt();
      chkn(n_rst, 1);
      chkn(n_irq, 2);
      rd(A_CTRL, 8'h20, OK);
   endtask : t_rst

   task automatic t_rst_stop();
      stop <= 1'b1;
      refresh();
      wait_evt();
      stop <= 1'b0;
      chkn(n_rec, 2);
      chkn(n_rst, 1);
      chkn(n_irq, 2);
      rd(A_CTRL, 8'h60, OK);
   endtask : t_rst_stop

   task automatic t_cause();
      cause_pulse(4'h8);
      cause_pulse(4'h1);
      rd(A_CTRL, 8'h40, OK);
      cause_pulse(4'h4);
      rd(A_CTRL, 8'h80, OK);
   endtask : t_cause

   task automatic t_stop_cfg();
      unlock();
      wr(A_CTRL, `WDG_CODE_SM_OFF, OK);
      rd(A_CTRL, 8'h01, OK);
      stop <= 1'b1;
      @(posedge clk_i);
      @(posedge clk_i);
      chk8({7'h00, osc_en}, 8'h00);
      stop <= 1'b0;
      @(posedge clk_i);
      @(posedge clk_i);
      chk8({7'h00, osc_en}, 8'h01);
      unlock();
      wr(A_CTRL, `WDG_CODE_SM_ON, OK);
      rd(A_CTRL, 8'h00, OK);
      stop <= 1'b1;
      @(posedge clk_i);
      @(posedge clk_i);
      chk8({7'h00, osc_en}, 8'h01);
      stop <= 1'b0;
   endtask : t_stop_cfg

   task automatic t_relock();
      wr(A_CTRL, `WDG_CODE_UNLOCK1, OK);
      wr(A_LO, 8'h77, OK);
      wr(A_CTRL, `WDG_CODE_UNLOCK2, OK);
      wr(A_UP, 8'h11, OK);
      wr(A_HI, 8'h22, OK);
      wr(A_LO, 8'h33, OK);
      refresh();
      rd(A_UP, 8'h00, OK);
      rd(A_LO, 8'h08, OK);
      // Debug mode refreshes on every cycle, so ticks never move the count
      dbg <= 1'b1;
      run <= 1'b1;
      repeat (12) @(posedge clk_i);
      rd(A_LO, 8'h08, OK);
      dbg <= 1'b0;
      run <= 1'b0;
   endtask : t_relock

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_reload();
      t_int();
      t_int_stop();
      t_rst();
      t_rst_stop();
      t_cause();
      t_stop_cfg();
      t_relock();
      give_verdict();
   end

   initial
   begin
      #4000000;
      hang();
   end
endmodule : watchdog_timeout_and_reset_status_tb

`default_nettype wire
